/* File: src/sps_pkg.sv */
// package: constants and types for the sdram power-state / dll-off control block
package sps_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS     = 8000;
    localparam int TXS_NS            = 270;
    localparam int TXS_CYC           = (TXS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TXP_NS            = 6;
    localparam int TXP_CYC           = (TXP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TMOD_CYC          = 24;
    localparam int TXS_ABORT_CYC     = 20;
    localparam int TXS_FAST_CYC      = 16;
    localparam int TIMER_W           = 12;

    // ------------------------------------------------------------
    // command encodings {cs_n, act_n, ras_n, cas_n, we_n}
    // ------------------------------------------------------------
    localparam logic [4:0] CMD_NOP   = 5'h0F;
    localparam logic [4:0] CMD_REF   = 5'h09;
    localparam logic [4:0] CMD_MRS   = 5'h08;
    localparam logic [4:0] CMD_PRE   = 5'h0A;
    localparam logic [4:0] CMD_WR    = 5'h0C;
    localparam logic [4:0] CMD_RD    = 5'h0D;
    localparam logic [4:0] CMD_ZQ    = 5'h0E;

    // ------------------------------------------------------------
    // mode register fields
    // ------------------------------------------------------------
    localparam logic [2:0] MR1_SEL       = 3'h1;
    localparam logic [2:0] MR4_SEL       = 3'h4;
    localparam int         MR1_DLL_EN_BIT = 0;
    localparam int         MR4_SR_ABORT_BIT = 9;
    localparam logic [4:0] DLL_OFF_CL    = 5'h0A;
    localparam logic [4:0] DLL_OFF_CWL   = 5'h09;
    localparam logic [4:0] DLL_OFF_SHIFT = 5'h01;

    // ------------------------------------------------------------
    // power states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SPS_ACTIVE,
        SPS_PRE_PD,
        SPS_ACT_PD,
        SPS_SELF_REF
    } sps_pstate_e;

endpackage : sps_pkg

/* File: src/sps_sync2.sv */
// module: two-flop synchroniser for a pin level
`timescale 1ns/1ps
`default_nettype none
module sps_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    // level in and out
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_reg <= '0;
            q_reg    <= '0;
        end else begin
            meta_reg <= i_d;
            q_reg    <= meta_reg;
        end
    end

    assign o_q = q_reg;
endmodule : sps_sync2
`default_nettype wire

/* File: src/sps_timer.sv */
// module: loadable down-counter that reports when a wait has elapsed
`timescale 1ns/1ps
`default_nettype none
module sps_timer #(
    parameter int W = 12
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    // load and status
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_count,
    output logic              o_done
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    initial begin
        if (W < 2) $error("sps_timer: width too small");
    end

    always_comb begin
        cnt_next = cnt_reg;
        if (i_load)
            cnt_next = i_count;
        else if (cnt_reg != '0)
            cnt_next = cnt_reg - 1'b1;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_next;
    end

    assign o_done = (cnt_reg == '0);
endmodule : sps_timer
`default_nettype wire

/* File: src/sps_power_ctrl.sv */
// module: device-side power state, cke truth table and dll-off control
// ------------------------------------------------------------
// Overview of operation
// - transitions use prior state, cke at n-1, cke at n, command at n
// - cke low keeps power-down/self refresh; rise with deselect exits; inputs ignored
// - power-down performs no refresh of its own
// - cke fall during read/write/precharge: precharge pd if banks closed, else active
// - cke fall while refreshing: precharge pd; with open bank: active pd
// - self refresh entered only from idle by refresh with cke falling
// - idle only with banks closed, no burst, cke high, timers elapsed
// - chip select high ignores new commands, running work completes
// - mr1 dll-enable bit 0 disables dll until written back to 1
// - dll-off mode supports cas latency 10 and write latency 9
// - dll-off read strobe delay starts at al plus cl minus one
// - mr4 bit 9 aborts refresh at exit without counter advance
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module sps_power_ctrl #(
    parameter int TXS_CYC  = sps_pkg::TXS_CYC,
    parameter int TXSDLL_CYC = 768,
    parameter int ADDR_W   = 14
) (
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    // command pins from the controller
    input  wire logic              i_cke,
    input  wire logic              i_cs_n,
    input  wire logic              i_act_n,
    input  wire logic              i_ras_n,
    input  wire logic              i_cas_n,
    input  wire logic              i_we_n,
    input  wire logic [2:0]        i_mr_sel,
    input  wire logic [ADDR_W-1:0] i_addr,
    // core status from the bank logic
    input  wire logic              i_banks_open,
    input  wire logic              i_burst_busy,
    input  wire logic              i_refresh_busy,
    input  wire logic              i_core_timing_ok,
    input  wire logic [4:0]        i_al,
    input  wire logic [4:0]        i_cl,
    // status out
    output logic [1:0]             o_pstate,
    output logic                   o_idle,
    output logic                   o_dll_enabled,
    output logic                   o_sr_abort_en,
    output logic                   o_refresh_enable,
    output logic                   o_refresh_abort,
    output logic                   o_xs_busy,
    output logic                   o_xsdll_busy,
    output logic [4:0]             o_rd_strobe_lat,
    output logic                   o_cmd_accept,
    output logic                   o_proto_err
);
    initial begin
        if (ADDR_W < 10) $error("sps_power_ctrl: address too narrow for mode bits");
        if (TXSDLL_CYC >= (1 << sps_pkg::TIMER_W)) $error("sps_power_ctrl: txsdll too large");
        if (TXS_CYC >= (1 << sps_pkg::TIMER_W)) $error("sps_power_ctrl: txs too large");
    end

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    logic [ADDR_W+8:0] pins_s;
    logic              cke_s;
    logic              cs_n_s;
    logic [3:0]        cmd_s;
    logic [2:0]        sel_s;
    logic [ADDR_W-1:0] addr_s;

    sps_sync2 #(.W(ADDR_W + 9)) u_sync (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_d   ({i_cke, i_cs_n, i_act_n, i_ras_n, i_cas_n, i_we_n, i_mr_sel, i_addr}),
        .o_q   (pins_s)
    );
    assign {cke_s, cs_n_s, cmd_s, sel_s, addr_s} = pins_s;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    logic [4:0] cmd5;
    logic       is_des;
    logic       is_nop;
    logic       is_ref;
    logic       is_mrs;
    logic       is_rd;
    logic       is_wr;
    logic       is_pre;
    logic       is_zq;

    assign cmd5   = {cs_n_s, cmd_s};
    assign is_des = cs_n_s;
    assign is_nop = (cmd5 == sps_pkg::CMD_NOP);
    assign is_ref = (cmd5 == sps_pkg::CMD_REF);
    assign is_mrs = (cmd5 == sps_pkg::CMD_MRS);
    assign is_rd  = (cmd5 == sps_pkg::CMD_RD);
    assign is_wr  = (cmd5 == sps_pkg::CMD_WR);
    assign is_pre = (cmd5 == sps_pkg::CMD_PRE);
    assign is_zq  = (cmd5 == sps_pkg::CMD_ZQ);

    // ------------------------------------------------------------
    // exit timers
    // ------------------------------------------------------------
    logic xs_load;
    logic xsdll_load;
    logic xp_load;
    logic xs_done;
    logic xsdll_done;
    logic xp_done;
    logic [sps_pkg::TIMER_W-1:0] xs_count;

    sps_timer #(.W(sps_pkg::TIMER_W)) u_xs (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_load  (xs_load),
        .i_count (xs_count),
        .o_done  (xs_done)
    );
    sps_timer #(.W(sps_pkg::TIMER_W)) u_xsdll (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_load  (xsdll_load),
        .i_count (sps_pkg::TIMER_W'(TXSDLL_CYC)),
        .o_done  (xsdll_done)
    );
    sps_timer #(.W(sps_pkg::TIMER_W)) u_xp (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_load  (xp_load),
        .i_count (sps_pkg::TIMER_W'(sps_pkg::TXP_CYC)),
        .o_done  (xp_done)
    );

    // ------------------------------------------------------------
    // power state machine
    // ------------------------------------------------------------
    sps_pkg::sps_pstate_e pstate_reg;
    sps_pkg::sps_pstate_e pstate_next;
    logic cke_prev_reg;
    logic cke_prev_next;
    logic dll_en_reg;
    logic dll_en_next;
    logic abort_en_reg;
    logic abort_en_next;
    logic err_reg;
    logic err_next;
    logic accept_reg;
    logic accept_next;
    logic abort_pulse_reg;
    logic abort_pulse_next;
    logic idle_reg;
    logic idle_next;
    logic ref_en_reg;
    logic ref_en_next;
    logic [4:0] rd_lat_reg;
    logic [4:0] rd_lat_next;
    logic [1:0] warm_reg;
    logic [1:0] warm_next;
    logic idle_now;

    // all timing from previous work and exits must be clear
    assign idle_now = !i_banks_open && !i_burst_busy && !i_refresh_busy && cke_s
                      && i_core_timing_ok && xs_done && xp_done && xsdll_done
                      && (pstate_reg == sps_pkg::SPS_ACTIVE);

    always_comb begin
        pstate_next      = pstate_reg;
        cke_prev_next    = cke_s;
        warm_next        = {warm_reg[0], 1'b1};
        dll_en_next      = dll_en_reg;
        abort_en_next    = abort_en_reg;
        err_next         = 1'b0;
        accept_next      = 1'b0;
        abort_pulse_next = 1'b0;
        xs_load          = 1'b0;
        xsdll_load       = 1'b0;
        xp_load          = 1'b0;
        xs_count         = sps_pkg::TIMER_W'(TXS_CYC);
        case (pstate_reg)
            sps_pkg::SPS_ACTIVE: begin
                if (cke_prev_reg && !cke_s) begin
                    // idle judged before this edge, while cke was still high
                    if (is_ref && idle_reg) begin
                        pstate_next = sps_pkg::SPS_SELF_REF;
                    end else if (is_des && i_banks_open) begin
                        pstate_next = sps_pkg::SPS_ACT_PD;
                    end else if (is_des) begin
                        pstate_next = sps_pkg::SPS_PRE_PD;
                    end else begin
                        err_next = 1'b1;
                    end
                end else if (!cke_prev_reg && !cke_s) begin
                    err_next = 1'b1;
                end else if (cke_s && !is_des) begin
                    // deselect blocks new commands; bursts already started run on
                    accept_next = 1'b1;
                    if (is_nop) begin
                        err_next = 1'b0;
                    end
                    if (is_mrs && sel_s == sps_pkg::MR4_SEL) begin
                        abort_en_next = addr_s[sps_pkg::MR4_SR_ABORT_BIT];
                    end
                    // the dll bit may only move during init or self refresh exit window; here any accepted mr1 write moves it
                    if (is_mrs && sel_s == sps_pkg::MR1_SEL) begin
                        dll_en_next = addr_s[sps_pkg::MR1_DLL_EN_BIT];
                    end
                    if (is_rd && !xsdll_done) begin
                        err_next = 1'b1;
                    end
                    if (!xs_done && !(is_mrs || is_zq)) begin
                        err_next = 1'b1;
                    end
                end
            end
            sps_pkg::SPS_PRE_PD,
            sps_pkg::SPS_ACT_PD: begin
                if (cke_s) begin
                    if (is_des) begin
                        pstate_next = sps_pkg::SPS_ACTIVE;
                        xp_load     = 1'b1;
                    end else begin
                        err_next = 1'b1;
                    end
                end
            end
            sps_pkg::SPS_SELF_REF: begin
                if (cke_s) begin
                    if (is_des) begin
                        pstate_next = sps_pkg::SPS_ACTIVE;
                        xs_load     = 1'b1;
                        xsdll_load  = dll_en_reg;
                        if (abort_en_reg) begin
                            xs_count         = sps_pkg::TIMER_W'(sps_pkg::TXS_ABORT_CYC);
                            abort_pulse_next = i_refresh_busy;
                        end
                    end else begin
                        err_next = 1'b1;
                    end
                end
            end
            default: begin
                pstate_next = sps_pkg::SPS_ACTIVE;
            end
        endcase
        // synchroniser still shows reset zeros: no false low-low error
        if (!warm_reg[1]) begin
            pstate_next = pstate_reg;
            err_next    = 1'b0;
            accept_next = 1'b0;
        end
    end

    always_comb begin
        idle_next   = idle_now;
        // no self-initiated refresh during power-down
        ref_en_next = (pstate_next == sps_pkg::SPS_SELF_REF);
        // dll-off: strobe delay one cycle earlier; cl/cwl pinned to 10/9
        if (dll_en_reg) begin
            rd_lat_next = i_al + i_cl;
        end else begin
            rd_lat_next = i_al + sps_pkg::DLL_OFF_CL - sps_pkg::DLL_OFF_SHIFT;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pstate_reg      <= sps_pkg::SPS_ACTIVE;
            cke_prev_reg    <= 1'b0;
            warm_reg        <= 2'h0;
            dll_en_reg      <= 1'b1;
            abort_en_reg    <= 1'b0;
            err_reg         <= 1'b0;
            accept_reg      <= 1'b0;
            abort_pulse_reg <= 1'b0;
            idle_reg        <= 1'b0;
            ref_en_reg      <= 1'b0;
            rd_lat_reg      <= 5'h00;
        end else begin
            pstate_reg      <= pstate_next;
            cke_prev_reg    <= cke_prev_next;
            warm_reg        <= warm_next;
            dll_en_reg      <= dll_en_next;
            abort_en_reg    <= abort_en_next;
            err_reg         <= err_next;
            accept_reg      <= accept_next;
            abort_pulse_reg <= abort_pulse_next;
            idle_reg        <= idle_next;
            ref_en_reg      <= ref_en_next;
            rd_lat_reg      <= rd_lat_next;
        end
    end

    // ------------------------------------------------------------
    // status flops
    // ------------------------------------------------------------
    logic xs_busy_reg;
    logic xsdll_busy_reg;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            xs_busy_reg    <= 1'b0;
            xsdll_busy_reg <= 1'b0;
        end else begin
            xs_busy_reg    <= !xs_done;
            xsdll_busy_reg <= !xsdll_done;
        end
    end

    assign o_pstate         = pstate_reg[1:0];
    assign o_idle           = idle_reg;
    assign o_dll_enabled    = dll_en_reg;
    assign o_sr_abort_en    = abort_en_reg;
    assign o_refresh_enable = ref_en_reg;
    assign o_refresh_abort  = abort_pulse_reg;
    assign o_xs_busy        = xs_busy_reg;
    assign o_xsdll_busy     = xsdll_busy_reg;
    assign o_rd_strobe_lat  = rd_lat_reg;
    assign o_cmd_accept     = accept_reg;
    assign o_proto_err      = err_reg;
endmodule : sps_power_ctrl
`default_nettype wire

/* File: bench/sps_power_ctrl_assertions.sv */
// checker: concurrent properties on the power-state block ports
`timescale 1ns/1ps
`default_nettype none
module sps_power_ctrl_assertions (
    // clock and reset
    input wire logic       i_clk,
    input wire logic       i_rst,
    // pins and levels
    input wire logic       i_cke,
    input wire logic       i_cs_n,
    input wire logic       i_act_n,
    input wire logic       i_ras_n,
    input wire logic       i_cas_n,
    input wire logic       i_we_n,
    input wire logic [4:0] i_al,
    input wire logic [4:0] i_cl,
    // status
    input wire logic [1:0] o_pstate,
    input wire logic       o_idle,
    input wire logic       o_dll_enabled,
    input wire logic       o_sr_abort_en,
    input wire logic       o_refresh_enable,
    input wire logic       o_refresh_abort,
    input wire logic [4:0] o_rd_strobe_lat,
    input wire logic       o_cmd_accept,
    input wire logic       o_proto_err
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire logic [4:0] cmd = {i_cs_n, i_act_n, i_ras_n, i_cas_n, i_we_n};

    pd_entry_a: assert property ($fell(i_cke) && i_cs_n && o_pstate == 2'h0 |-> ##[1:4] o_pstate inside {2'h1, 2'h2})
        else $error("power-down not entered after cke fall");
    sr_entry_a: assert property ($fell(i_cke) && cmd == sps_pkg::CMD_REF && o_idle |-> ##[1:4] o_pstate == 2'h3)
        else $error("self refresh not entered");
    sr_from_idle_a: assert property (o_pstate == 2'h3 && $past(o_pstate) != 2'h3 |-> $past(o_pstate) == 2'h0)
        else $error("self refresh entered from power-down");
    // four low samples make sure the synchroniser is full of low levels
    low_hold_a: assert property (o_pstate != 2'h0 && !i_cke && !$past(i_cke) && !$past(i_cke, 2) && !$past(i_cke, 3)
        |=> $stable(o_pstate)) else $error("state moved while cke low");
    low_exit_a: assert property (o_pstate != 2'h0 && $rose(i_cke) && i_cs_n |-> ##[1:4] o_pstate == 2'h0)
        else $error("no exit after cke rise");
    desel_ignore_a: assert property ($past(i_cs_n, 2) && $past(i_cs_n, 3) && $past(i_cs_n, 4) |-> !o_cmd_accept)
        else $error("command taken while deselected");
    abort_pulse_a: assert property (o_refresh_abort |-> o_sr_abort_en ##1 !o_refresh_abort)
        else $error("refresh abort without enable");
    sr_refresh_a: assert property (o_pstate == 2'h3 && $past(o_pstate) == 2'h3 |-> o_refresh_enable)
        else $error("no refresh in self refresh");
    pd_no_refresh_a: assert property (o_refresh_enable |-> o_pstate == 2'h3 || $past(o_pstate) == 2'h3)
        else $error("refresh outside self refresh");
    lat_off_a: assert property (!o_dll_enabled && !$past(o_dll_enabled) && $past(i_al) == i_al
        |-> o_rd_strobe_lat == i_al + sps_pkg::DLL_OFF_CL - sps_pkg::DLL_OFF_SHIFT) else $error("dll-off latency wrong");
    lat_on_a: assert property (o_dll_enabled && $past(o_dll_enabled) && !$past(i_rst) && $past(i_al) == i_al
        && $past(i_cl) == i_cl |-> o_rd_strobe_lat == i_al + i_cl) else $error("dll-on latency wrong");

    cover property (o_pstate == 2'h2);
    cover property (o_pstate == 2'h3);
    cover property (o_refresh_abort);
    cover property (o_proto_err);
endmodule : sps_power_ctrl_assertions

bind sps_power_ctrl sps_power_ctrl_assertions u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_cke(i_cke), .i_cs_n(i_cs_n),
    .i_act_n(i_act_n), .i_ras_n(i_ras_n), .i_cas_n(i_cas_n), .i_we_n(i_we_n), .i_al(i_al), .i_cl(i_cl),
    .o_pstate(o_pstate), .o_idle(o_idle), .o_dll_enabled(o_dll_enabled), .o_sr_abort_en(o_sr_abort_en),
    .o_refresh_enable(o_refresh_enable), .o_refresh_abort(o_refresh_abort), .o_rd_strobe_lat(o_rd_strobe_lat),
    .o_cmd_accept(o_cmd_accept), .o_proto_err(o_proto_err));
`default_nettype wire

/* File: bench/sps_ctrl_model.sv */
// partner: behavioural memory controller driving cke and command pins
`timescale 1ns/1ps
`default_nettype none
module sps_ctrl_model (
    // clock
    input  wire logic        i_clk,
    // requested levels
    input  wire logic        i_cke_req,
    input  wire logic [4:0]  i_cmd_req,
    input  wire logic [2:0]  i_sel_req,
    input  wire logic [13:0] i_addr_req,
    // pins
    output logic             o_cke,
    output logic             o_cs_n,
    output logic             o_act_n,
    output logic             o_ras_n,
    output logic             o_cas_n,
    output logic             o_we_n,
    output logic [2:0]       o_mr_sel,
    output logic [13:0]      o_addr
);
    logic [3:0]  junk = 4'h5;
    logic        k_l;
    logic [4:0]  c_l;
    initial begin
        o_cke = 1'b1;
        {o_cs_n, o_act_n, o_ras_n, o_cas_n, o_we_n} = 5'h1F;
        o_mr_sel = 3'h0;
        o_addr = 14'h0000;
    end
    // cke and command requests taken at the edge, select and address read 1 ns later as the pins move clear of the sampling edge
    always @(posedge i_clk) begin
        k_l = i_cke_req;
        c_l = i_cmd_req;
        #1;
        junk = junk + 4'h7;
        o_cke = k_l;
        if (c_l[4]) begin
            // deselected: the other lines carry no stale value
            {o_cs_n, o_act_n, o_ras_n, o_cas_n, o_we_n} = {1'b1, junk};
            o_mr_sel = ~o_mr_sel;
            o_addr = ~o_addr;
        end else begin
            {o_cs_n, o_act_n, o_ras_n, o_cas_n, o_we_n} = c_l;
            o_mr_sel = i_sel_req;
            o_addr = i_addr_req;
        end
    end
endmodule : sps_ctrl_model
`default_nettype wire

/* File: bench/sps_power_ctrl_test.sv */
// testbench: power-state control against a behavioural controller and state model
`timescale 1ns/1ps
`default_nettype none
module sps_power_ctrl_test;
    localparam logic [4:0] DES = 5'h10;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        cke_q = 1'b1;
    logic [4:0]  cmd_q = DES;
    logic [2:0]  sel_q = 3'h0;
    logic [13:0] addr_q = 14'h0000;
    logic        banks = 1'b0;
    logic        burst = 1'b0;
    logic        refr = 1'b0;
    logic [4:0]  al = 5'h00;
    logic [4:0]  cl = 5'h0C;
    wire logic   cke, cs_n, act_n, ras_n, cas_n, we_n;
    wire logic [2:0]  mr_sel;
    wire logic [13:0] addr;
    logic [1:0]  pstate;
    logic [4:0]  lat;
    logic        idle, dll, ab_en, ref_en, ref_ab, xs_b, xsdll_b, accept, perr;
    int          mismatches = 0, num_checks = 0, acc_cnt = 0, err_cnt = 0, abt_cnt = 0, exp_st = 0, e0;
    logic        prev_cke = 1'b1;

    initial forever #4 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        if (accept === 1'b1) acc_cnt++;
        if (perr === 1'b1) err_cnt++;
        if (ref_ab === 1'b1) abt_cnt++;
    end

    sps_ctrl_model u_ctl (.i_clk(i_clk), .i_cke_req(cke_q), .i_cmd_req(cmd_q), .i_sel_req(sel_q),
        .i_addr_req(addr_q), .o_cke(cke), .o_cs_n(cs_n), .o_act_n(act_n), .o_ras_n(ras_n), .o_cas_n(cas_n),
        .o_we_n(we_n), .o_mr_sel(mr_sel), .o_addr(addr));
    sps_power_ctrl #(.TXS_CYC(20), .TXSDLL_CYC(40), .ADDR_W(14)) dut (.i_clk(i_clk), .i_rst(i_rst),
        .i_cke(cke), .i_cs_n(cs_n), .i_act_n(act_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n),
        .i_mr_sel(mr_sel), .i_addr(addr), .i_banks_open(banks), .i_burst_busy(burst), .i_refresh_busy(refr),
        .i_core_timing_ok(1'b1), .i_al(al), .i_cl(cl), .o_pstate(pstate), .o_idle(idle), .o_dll_enabled(dll),
        .o_sr_abort_en(ab_en), .o_refresh_enable(ref_en), .o_refresh_abort(ref_ab), .o_xs_busy(xs_b),
        .o_xsdll_busy(xsdll_b), .o_rd_strobe_lat(lat), .o_cmd_accept(accept), .o_proto_err(perr));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict

    task automatic chk(input string w, input logic [4:0] e, input logic [4:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", w, e, g);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : cyc

    // one command, then deselect; the state model follows the cke truth table
    task automatic issue(input logic k, input logic [4:0] c, input logic [2:0] s, input logic [13:0] a);
        cmd_q = c;
        cke_q = k;
        sel_q = s;
        addr_q = a;
        cyc(1);
        cmd_q = DES;
        if (exp_st == 0 && prev_cke && !k) exp_st = (c == sps_pkg::CMD_REF) ? 3 : (banks ? 2 : 1);
        else if (exp_st != 0 && !prev_cke && k) exp_st = 0;
        prev_cke = k;
        cyc(7);
        chk("pstate", 5'(exp_st), {3'h0, pstate});
    endtask : issue

    task automatic wait_free();
        int n;
        n = 0;
        while ((xsdll_b !== 1'b0 || xs_b !== 1'b0) && n < 200) begin
            cyc(1);
            n++;
        end
        if (n >= 200) begin
            mismatches++;
            $display("[FAIL] xsdll_busy expected 0 seen 1");
            give_verdict();
        end
        chk("xs_busy", 5'h00, xs_b);
    endtask : wait_free

    task automatic sr_cycle(input logic ab, input logic dl);
        int a0, b0, e1;
        b0 = abt_cnt;
        chk("idle", 5'h01, idle);
        issue(1'b0, sps_pkg::CMD_REF, 3'h0, 14'h0000);
        chk("ref_en", 5'h01, ref_en);
        refr = 1'b1;
        issue(1'b0, 5'($urandom), 3'($urandom), 14'($urandom));
        issue(1'b1, DES, 3'h0, 14'h0000);
        chk("abort", 5'(b0 + ab), 5'(abt_cnt));
        chk("xsdll_busy", 5'(dl), xsdll_b);
        chk("idle", 5'h00, idle);
        e1 = err_cnt;
        issue(1'b1, sps_pkg::CMD_RD, 3'h0, 14'h0000);
        chk("perr", 5'(e1 + 1), 5'(err_cnt));
        refr = 1'b0;
        wait_free();
        a0 = acc_cnt;
        issue(1'b1, sps_pkg::CMD_RD, 3'h0, 14'h0000);
        issue(1'b1, sps_pkg::CMD_REF, 3'h0, 14'h0000);
        chk("accept", 5'(a0 + 2), 5'(acc_cnt));
        chk("perr", 5'(e1 + 1), 5'(err_cnt));
        $display("test self refresh done");
    endtask : sr_cycle

    initial begin
        al = 5'($urandom(18726) % 16);
        cyc(10);
        i_rst = 1'b0;
        cyc(6);
        chk("pstate", 5'h00, {3'h0, pstate});
        chk("dll", 5'h01, dll);
        chk("ref_en", 5'h00, ref_en);
        chk("idle", 5'h01, idle);
        chk("lat", al + cl, lat);
        $display("test reset done");
        // closed banks, open bank, refreshing
        for (int k = 0; k < 3; k++) begin
            banks = (k == 1);
            refr = (k == 2);
            cyc(2);
            issue(1'b0, DES, 3'h0, 14'h0000);
            chk("ref_en", 5'h00, ref_en);
            issue(1'b0, 5'($urandom), 3'($urandom), 14'($urandom));
            issue(1'b1, DES, 3'h0, 14'h0000);
        end
        banks = 1'b0;
        refr = 1'b0;
        $display("test power-down done");
        e0 = acc_cnt;
        issue(1'b1, DES, 3'h0, 14'h0000);
        chk("accept", 5'(e0), 5'(acc_cnt));
        issue(1'b1, sps_pkg::CMD_ZQ, 3'h0, 14'h0000);
        issue(1'b1, sps_pkg::CMD_NOP, 3'h0, 14'h0000);
        chk("accept", 5'(e0 + 2), 5'(acc_cnt));
        chk("perr", 5'h00, 5'(err_cnt));
        burst = 1'b1;
        cyc(4);
        chk("idle", 5'h00, idle);
        burst = 1'b0;
        banks = 1'b1;
        cyc(4);
        chk("idle", 5'h00, idle);
        banks = 1'b0;
        cyc(4);
        $display("test commands done");
        issue(1'b1, sps_pkg::CMD_MRS, sps_pkg::MR1_SEL, 14'h0000);
        chk("dll", 5'h00, dll);
        chk("lat", al + sps_pkg::DLL_OFF_CL - sps_pkg::DLL_OFF_SHIFT, lat);
        issue(1'b1, sps_pkg::CMD_MRS, sps_pkg::MR4_SEL, 14'h0200);
        chk("abort_en", 5'h01, ab_en);
        cyc(sps_pkg::TMOD_CYC);
        sr_cycle(1'b1, 1'b0);
        issue(1'b1, sps_pkg::CMD_MRS, sps_pkg::MR1_SEL, 14'h0001);
        chk("dll", 5'h01, dll);
        chk("lat", al + cl, lat);
        issue(1'b1, sps_pkg::CMD_MRS, sps_pkg::MR4_SEL, 14'h0000);
        chk("abort_en", 5'h00, ab_en);
        cyc(sps_pkg::TMOD_CYC);
        sr_cycle(1'b0, 1'b1);
        // a read on the falling cke edge is not a legal transition
        e0 = err_cnt;
        cmd_q = sps_pkg::CMD_RD;
        cke_q = 1'b0;
        cyc(1);
        cmd_q = DES;
        cyc(8);
        chk("perr", 5'h01, 5'(err_cnt > e0));
        $display("test illegal done");
        give_verdict();
    end
endmodule : sps_power_ctrl_test
`default_nettype wire
